// ===== port_pin_pkg.sv
/*
  Shared constants for the port pin function and trigger block: register
  addresses, reset values, implemented-bit masks and pin bit positions.
  Assumes the CPU presents full 32-bit byte addresses, halfword aligned.
*/
package port_pin_pkg;

  // Register addresses (halfword aligned)
  localparam logic [31:0] ADDR_LOW_PORT_PIN_DATA = 32'hFFFFF000;
  localparam logic [31:0] ADDR_HIGH_PORT_PIN_DATA = 32'hFFFFF002;
  localparam logic [31:0] ADDR_TIMER_DMA_PIN_DATA = 32'hFFFFF00E;
  localparam logic [31:0] ADDR_LOW_PORT_DIRECTION = 32'hFFFFF020;
  localparam logic [31:0] ADDR_HIGH_PORT_DIRECTION = 32'hFFFFF022;
  localparam logic [31:0] ADDR_LOW_PORT_MODE_CONTROL = 32'hFFFFF040;
  localparam logic [31:0] ADDR_HIGH_PORT_MODE_CONTROL = 32'hFFFFF042;
  localparam logic [31:0] ADDR_LOW_PORT_FUNCTION_SELECT = 32'hFFFFF058;
  localparam logic [31:0] ADDR_TIMER_DMA_PIN_DIRECTION = 32'hFFFFF40E;
  localparam logic [31:0] ADDR_TIMER_DMA_PIN_MODE_CONTROL = 32'hFFFFF44E;
  localparam logic [31:0] ADDR_TIMER_DMA_PIN_FUNCTION_SELECT = 32'hFFFFF46E;
  localparam logic [31:0] ADDR_LOW_PORT_FALLING_SELECT = 32'hFFFFFC10;
  localparam logic [31:0] ADDR_LOW_PORT_RISING_SELECT = 32'hFFFFFC30;

  // Reset values
  localparam logic [15:0] RST_LOW_PORT_DIRECTION = 16'hFFFF;
  localparam logic [15:0] RST_LOW_PORT_MODE_CONTROL = 16'h0002;
  localparam logic [7:0] RST_LOW_PORT_FUNCTION_SELECT = 8'h03;
  localparam logic [7:0] RST_LOW_PORT_FALLING_SELECT = 8'h00;
  localparam logic [7:0] RST_LOW_PORT_RISING_SELECT = 8'h03;
  localparam logic [15:0] RST_HIGH_PORT_DIRECTION = 16'h03FF;
  localparam logic [15:0] RST_HIGH_PORT_MODE_CONTROL = 16'h03FF;
  localparam logic [7:0] RST_TIMER_DMA_PIN_DIRECTION = 8'hFC;
  localparam logic [7:0] RST_TIMER_DMA_PIN_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_TIMER_DMA_PIN_FUNCTION_SELECT = 8'h00;

  // Implemented bits
  localparam logic [7:0] TIMER_DMA_PIN_MASK = 8'hFC;

  // Function select bit positions of the six-pin port
  localparam int C3_OUT_BIT = 7;
  localparam int C3_CAP1_BIT = 6;
  localparam int C3_CAP0_BIT = 5;
  localparam int C2_OUT_BIT = 4;
  localparam int C2_CAP1_BIT = 3;
  localparam int C2_CAP0_BIT = 2;

  // Level detection sample period in main clock cycles
  localparam int LEVEL_SAMPLE_DIV = 4;

endpackage : port_pin_pkg

// ===== pin_trigger.sv
/*
  One external interrupt pin: three-stage synchroniser, edge and low-level
  trigger detection and the sticky request flag.
  Assumes sample_en_i is a one-cycle pulse every few main clock cycles.
*/
module pin_trigger (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic pin_i,
  input wire logic enable_i,
  input wire logic falling_sel_i,
  input wire logic rising_sel_i,
  input wire logic sample_en_i,
  input wire logic clear_i,
  output logic level_o,
  output logic flag_o
);

  typedef struct packed {
    logic [2:0] sync;
    logic stable;
    logic flag;
  } trig_t;

  trig_t cur;
  trig_t next_cur;
  logic agree;
  logic rise;
  logic fall;
  logic set;

  always_comb begin
    next_cur = cur;
    next_cur.sync = {cur.sync[1:0], pin_i};
    agree = (cur.sync[1] == cur.sync[2]);
    rise = agree && cur.sync[2] && !cur.stable;
    fall = agree && !cur.sync[2] && cur.stable;
    if (agree) begin
      next_cur.stable = cur.sync[2];
    end
    unique case ({falling_sel_i, rising_sel_i})
      2'b00: set = fall;
      2'b01: set = rise;
      2'b10: set = sample_en_i && !cur.stable;
      default: set = rise || fall;
    endcase
    set = set && enable_i;
    // Set beats clear so a level still low re-raises the flag at the next sample strobe
    next_cur.flag = set || (cur.flag && !clear_i);
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cur <= '{sync: 3'h7, stable: 1'b1, flag: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign level_o = cur.stable;
  assign flag_o = cur.flag;

endmodule : pin_trigger

// ===== port_pin_function.sv
/*
  Pin multiplexing for the six-pin timer/DMA port, the 2-bit low address
  port and the 10-bit high address port, with their registers and the
  low port interrupt triggers.
  Assumes a simple CPU register port with a per-bit write mask, so 16-,
  8- and 1-bit writes are all one mask; pads combine out, oe and in.
*/
//
// Behaviour
// - Top six-pin bit 7 picks timer C3 compare or DMA3 end output.
// - Bit 6 picks timer C3 capture interrupt input or DMA3 acknowledge output.
// - Bit 5 picks timer C3 capture/count input or DMA3 request input.
// - Bits 4 and 3 do the same for timer C2 and DMA2.
// - Bit 2 picks timer C2 capture/count input or DMA2 request input.
// - Function select is ignored while its pin is in port mode.
// - Low address port is 16 bits wide; only pins 1 and 0 exist.
// - Low direction register: bits 15 to 2 read-only, bits 1 and 0 writable, resets FFFFH.
// - Low mode control: upper byte read-only, resets 0002H.
// - Low function bits pick interrupt input or address A1/A0; reset 03H.
// - Falling/rising pair: 00 fall, 01 rise, 10 low level, 11 both.
// - Rising and falling selects are writable per bit, independent per pin.
// - Low level is sampled every four main clocks and latched as a flag.
// - A held low level re-sets the flag at the next sample strobe after it is cleared.
// - A level request stays pending until its flag is cleared.
// - High address port has ten pins with per-bit direction.
// - High port in control mode drives address lines A25 to A16.
// - High mode control bit 1 selects address output; resets 03FFH.
module port_pin_function
  import port_pin_pkg::*;
#(
  parameter int SAMPLE_DIV = LEVEL_SAMPLE_DIV
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // CPU register port
  input wire logic [31:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] wmask_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  // Six-pin port, bits 7 to 2 used
  input wire logic [7:0] timer_dma_pin_i,
  output logic [7:0] timer_dma_pin_o,
  output logic [7:0] timer_dma_pin_oe_o,
  // Low address port
  input wire logic [1:0] low_port_pin_i,
  output logic [1:0] low_port_pin_o,
  output logic [1:0] low_port_pin_oe_o,
  // High address port
  input wire logic [9:0] high_port_pin_i,
  output logic [9:0] high_port_pin_o,
  output logic [9:0] high_port_pin_oe_o,
  // On-chip units
  input wire logic timer_c3_compare_output_i,
  input wire logic dma3_transfer_end_output_i,
  input wire logic dma3_acknowledge_output_i,
  input wire logic timer_c2_compare_output_i,
  input wire logic dma2_transfer_end_output_i,
  input wire logic dma2_acknowledge_output_i,
  input wire logic [1:0] address_low_i,
  input wire logic [9:0] address_high_i,
  output logic timer_c3_capture1_interrupt_input_o,
  output logic timer_c3_capture0_interrupt_input_o,
  output logic timer_c3_count_input_o,
  output logic dma3_request_input_o,
  output logic timer_c2_capture1_interrupt_input_o,
  output logic timer_c2_capture0_interrupt_input_o,
  output logic timer_c2_count_input_o,
  output logic dma2_request_input_o,
  // Low port interrupt request flags and their clear
  input wire logic [1:0] low_port_request_clear_i,
  output logic [1:0] low_port_request_flag_o
);

  // The sample divider counts in eight bits, so longer periods cannot be served
  if (SAMPLE_DIV < 2 || SAMPLE_DIV > 256) begin : g_bad_div
    $error("SAMPLE_DIV must lie in 2..256");
  end

  typedef struct packed {
    logic [15:0] rdata;
    logic [7:0] div;
    logic sample_en;
    logic [7:0] p7_data;
    logic [7:0] p7_dir;
    logic [7:0] p7_mode;
    logic [7:0] p7_func;
    logic [7:0] p7_s1;
    logic [7:0] p7_s2;
    logic [7:0] p7_s3;
    logic [7:0] p7_stable;
    logic [1:0] lo_data;
    logic [1:0] lo_dir;
    logic [1:0] lo_mode;
    logic [1:0] lo_func;
    logic [1:0] lo_fall;
    logic [1:0] lo_rise;
    logic [9:0] hi_data;
    logic [9:0] hi_dir;
    logic [9:0] hi_mode;
    logic [9:0] hi_s1;
    logic [9:0] hi_s2;
    logic [9:0] hi_s3;
    logic [9:0] hi_stable;
    logic [7:0] p7_out;
    logic [7:0] p7_oe;
    logic [1:0] lo_out;
    logic [1:0] lo_oe;
    logic [9:0] hi_out;
    logic [9:0] hi_oe;
    logic [7:0] unit_in;
  } state_t;

  localparam logic [7:0] DIV_LAST = 8'(SAMPLE_DIV - 1);

  state_t cur;
  state_t next_cur;
  logic [1:0] lo_level;
  logic [1:0] lo_int_en;

  // Each of the two interrupt pins gets its own trigger structure
  for (genvar n = 0; n < 2; n++) begin : g_low_trig
    pin_trigger u_trig (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .pin_i(low_port_pin_i[n]),
      .enable_i(lo_int_en[n]),
      .falling_sel_i(cur.lo_fall[n]),
      .rising_sel_i(cur.lo_rise[n]),
      .sample_en_i(cur.sample_en),
      .clear_i(low_port_request_clear_i[n]),
      .level_o(lo_level[n]),
      .flag_o(low_port_request_flag_o[n])
    );
  end

  // Only a control-mode pin with interrupt function raises requests
  assign lo_int_en = cur.lo_mode & ~cur.lo_func;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] keep);
    merge = (old & ~(wmask_i & keep)) | (wdata_i & wmask_i & keep);
  endfunction : merge

  always_comb begin
    logic [15:0] rd;
    logic [7:0] p7_in;
    logic [7:0] sel;
    next_cur = cur;
    rd = 16'h0000;
    p7_in = cur.p7_stable;
    sel = cur.p7_func;

    // Divider for the level detection sample strobe
    next_cur.sample_en = (cur.div == DIV_LAST);
    next_cur.div = next_cur.sample_en ? 8'h00 : 8'(cur.div + 8'h01);

    // Three-stage synchronisers; a change counts once stages two and three agree
    next_cur.p7_s1 = timer_dma_pin_i;
    next_cur.p7_s2 = cur.p7_s1;
    next_cur.p7_s3 = cur.p7_s2;
    next_cur.p7_stable = (cur.p7_s2 & cur.p7_s3) | (cur.p7_stable & (cur.p7_s2 ^ cur.p7_s3));
    next_cur.hi_s1 = high_port_pin_i;
    next_cur.hi_s2 = cur.hi_s1;
    next_cur.hi_s3 = cur.hi_s2;
    next_cur.hi_stable = (cur.hi_s2 & cur.hi_s3) | (cur.hi_stable & (cur.hi_s2 ^ cur.hi_s3));

    if (wr_i) begin
      unique case (addr_i)
        ADDR_TIMER_DMA_PIN_DATA: next_cur.p7_data = 8'(merge({8'h00, cur.p7_data}, {8'h00, TIMER_DMA_PIN_MASK}));
        ADDR_TIMER_DMA_PIN_DIRECTION: next_cur.p7_dir = 8'(merge({8'h00, cur.p7_dir}, {8'h00, TIMER_DMA_PIN_MASK}));
        ADDR_TIMER_DMA_PIN_MODE_CONTROL: next_cur.p7_mode = 8'(merge({8'h00, cur.p7_mode}, {8'h00, TIMER_DMA_PIN_MASK}));
        ADDR_TIMER_DMA_PIN_FUNCTION_SELECT: next_cur.p7_func = 8'(merge({8'h00, cur.p7_func}, {8'h00, TIMER_DMA_PIN_MASK}));
        ADDR_LOW_PORT_PIN_DATA: next_cur.lo_data = 2'(merge({14'h0000, cur.lo_data}, 16'h0003));
        ADDR_LOW_PORT_DIRECTION: next_cur.lo_dir = 2'(merge({14'h0000, cur.lo_dir}, 16'h0003));
        ADDR_LOW_PORT_MODE_CONTROL: next_cur.lo_mode = 2'(merge({14'h0000, cur.lo_mode}, 16'h0003));
        ADDR_LOW_PORT_FUNCTION_SELECT: next_cur.lo_func = 2'(merge({14'h0000, cur.lo_func}, 16'h0003));
        ADDR_LOW_PORT_FALLING_SELECT: next_cur.lo_fall = 2'(merge({14'h0000, cur.lo_fall}, 16'h0003));
        ADDR_LOW_PORT_RISING_SELECT: next_cur.lo_rise = 2'(merge({14'h0000, cur.lo_rise}, 16'h0003));
        ADDR_HIGH_PORT_PIN_DATA: next_cur.hi_data = 10'(merge({6'h00, cur.hi_data}, 16'h03FF));
        ADDR_HIGH_PORT_DIRECTION: next_cur.hi_dir = 10'(merge({6'h00, cur.hi_dir}, 16'h03FF));
        ADDR_HIGH_PORT_MODE_CONTROL: next_cur.hi_mode = 10'(merge({6'h00, cur.hi_mode}, 16'h03FF));
        default: ;
      endcase
    end

    // Pin data reads the pad in input mode and the latch in output mode
    unique case (addr_i)
      ADDR_TIMER_DMA_PIN_DATA: rd = {8'h00, ((cur.p7_dir & p7_in) | (~cur.p7_dir & cur.p7_data)) & TIMER_DMA_PIN_MASK};
      ADDR_TIMER_DMA_PIN_DIRECTION: rd = {8'h00, cur.p7_dir};
      ADDR_TIMER_DMA_PIN_MODE_CONTROL: rd = {8'h00, cur.p7_mode};
      ADDR_TIMER_DMA_PIN_FUNCTION_SELECT: rd = {8'h00, cur.p7_func};
      ADDR_LOW_PORT_PIN_DATA: rd = {14'h0000, (cur.lo_dir & lo_level) | (~cur.lo_dir & cur.lo_data)};
      ADDR_LOW_PORT_DIRECTION: rd = {RST_LOW_PORT_DIRECTION[15:2], cur.lo_dir};
      ADDR_LOW_PORT_MODE_CONTROL: rd = {14'h0000, cur.lo_mode};
      ADDR_LOW_PORT_FUNCTION_SELECT: rd = {14'h0000, cur.lo_func};
      ADDR_LOW_PORT_FALLING_SELECT: rd = {14'h0000, cur.lo_fall};
      ADDR_LOW_PORT_RISING_SELECT: rd = {14'h0000, cur.lo_rise};
      ADDR_HIGH_PORT_PIN_DATA: rd = {6'h00, (cur.hi_dir & cur.hi_stable) | (~cur.hi_dir & cur.hi_data)};
      ADDR_HIGH_PORT_DIRECTION: rd = {6'h00, cur.hi_dir};
      ADDR_HIGH_PORT_MODE_CONTROL: rd = {6'h00, cur.hi_mode};
      default: rd = 16'h0000;
    endcase
    if (rd_i) begin
      next_cur.rdata = rd;
    end

    // Six-pin port: port mode first, control mode overrides per pin
    next_cur.p7_out = cur.p7_data & TIMER_DMA_PIN_MASK;
    next_cur.p7_oe = ~cur.p7_dir & TIMER_DMA_PIN_MASK;
    next_cur.unit_in = 8'h00;
    if (cur.p7_mode[C3_OUT_BIT]) begin
      next_cur.p7_oe[C3_OUT_BIT] = 1'b1;
      next_cur.p7_out[C3_OUT_BIT] = sel[C3_OUT_BIT] ? dma3_transfer_end_output_i : timer_c3_compare_output_i;
    end
    if (cur.p7_mode[C3_CAP1_BIT]) begin
      next_cur.p7_oe[C3_CAP1_BIT] = sel[C3_CAP1_BIT];
      next_cur.p7_out[C3_CAP1_BIT] = dma3_acknowledge_output_i;
      next_cur.unit_in[0] = !sel[C3_CAP1_BIT] && p7_in[C3_CAP1_BIT];
    end
    if (cur.p7_mode[C3_CAP0_BIT]) begin
      next_cur.p7_oe[C3_CAP0_BIT] = 1'b0;
      // Capture and count share the pin; the timer decides which it uses
      next_cur.unit_in[1] = !sel[C3_CAP0_BIT] && p7_in[C3_CAP0_BIT];
      next_cur.unit_in[2] = sel[C3_CAP0_BIT] && p7_in[C3_CAP0_BIT];
    end
    if (cur.p7_mode[C2_OUT_BIT]) begin
      next_cur.p7_oe[C2_OUT_BIT] = 1'b1;
      next_cur.p7_out[C2_OUT_BIT] = sel[C2_OUT_BIT] ? dma2_transfer_end_output_i : timer_c2_compare_output_i;
    end
    if (cur.p7_mode[C2_CAP1_BIT]) begin
      next_cur.p7_oe[C2_CAP1_BIT] = sel[C2_CAP1_BIT];
      next_cur.p7_out[C2_CAP1_BIT] = dma2_acknowledge_output_i;
      next_cur.unit_in[4] = !sel[C2_CAP1_BIT] && p7_in[C2_CAP1_BIT];
    end
    if (cur.p7_mode[C2_CAP0_BIT]) begin
      next_cur.p7_oe[C2_CAP0_BIT] = 1'b0;
      next_cur.unit_in[5] = !sel[C2_CAP0_BIT] && p7_in[C2_CAP0_BIT];
      next_cur.unit_in[6] = sel[C2_CAP0_BIT] && p7_in[C2_CAP0_BIT];
    end

    // Low address port
    for (int n = 0; n < 2; n++) begin
      next_cur.lo_out[n] = cur.lo_data[n];
      next_cur.lo_oe[n] = !cur.lo_dir[n];
      if (cur.lo_mode[n]) begin
        next_cur.lo_oe[n] = cur.lo_func[n];
        next_cur.lo_out[n] = address_low_i[n];
      end
    end

    // High address port
    next_cur.hi_oe = cur.hi_mode | ~cur.hi_dir;
    next_cur.hi_out = (cur.hi_mode & address_high_i) | (~cur.hi_mode & cur.hi_data);
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cur <= '0;
      cur.p7_s1 <= 8'hFF;
      cur.p7_s2 <= 8'hFF;
      cur.p7_s3 <= 8'hFF;
      cur.p7_stable <= 8'hFF;
      cur.hi_s1 <= 10'h3FF;
      cur.hi_s2 <= 10'h3FF;
      cur.hi_s3 <= 10'h3FF;
      cur.hi_stable <= 10'h3FF;
      cur.p7_dir <= RST_TIMER_DMA_PIN_DIRECTION;
      cur.p7_mode <= RST_TIMER_DMA_PIN_MODE_CONTROL;
      cur.p7_func <= RST_TIMER_DMA_PIN_FUNCTION_SELECT;
      cur.lo_dir <= RST_LOW_PORT_DIRECTION[1:0];
      cur.lo_mode <= RST_LOW_PORT_MODE_CONTROL[1:0];
      cur.lo_func <= RST_LOW_PORT_FUNCTION_SELECT[1:0];
      cur.lo_fall <= RST_LOW_PORT_FALLING_SELECT[1:0];
      cur.lo_rise <= RST_LOW_PORT_RISING_SELECT[1:0];
      cur.hi_dir <= RST_HIGH_PORT_DIRECTION[9:0];
      cur.hi_mode <= RST_HIGH_PORT_MODE_CONTROL[9:0];
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata_o = cur.rdata;
  assign timer_dma_pin_o = cur.p7_out;
  assign timer_dma_pin_oe_o = cur.p7_oe;
  assign low_port_pin_o = cur.lo_out;
  assign low_port_pin_oe_o = cur.lo_oe;
  assign high_port_pin_o = cur.hi_out;
  assign high_port_pin_oe_o = cur.hi_oe;
  assign timer_c3_capture1_interrupt_input_o = cur.unit_in[0];
  assign timer_c3_capture0_interrupt_input_o = cur.unit_in[1];
  assign timer_c3_count_input_o = cur.unit_in[1];
  assign dma3_request_input_o = cur.unit_in[2];
  assign timer_c2_capture1_interrupt_input_o = cur.unit_in[4];
  assign timer_c2_capture0_interrupt_input_o = cur.unit_in[5];
  assign timer_c2_count_input_o = cur.unit_in[5];
  assign dma2_request_input_o = cur.unit_in[6];

endmodule : port_pin_function

// ===== port_pin_function_assertions.sv
/*
  Checker for port_pin_function: register read formats, flag
  stickiness and six-pin routing, watched at the top ports only.
  Assumes it is bound from the bench top; one clock domain.
*/
module port_pin_function_chk
  import port_pin_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [31:0] addr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [7:0] timer_dma_pin_i,
  input wire logic [1:0] low_port_request_clear_i,
  input wire logic [1:0] low_port_request_flag_o,
  input wire logic timer_c3_capture0_interrupt_input_o,
  input wire logic timer_c3_count_input_o,
  input wire logic dma3_request_input_o,
  input wire logic timer_c2_count_input_o,
  input wire logic dma2_request_input_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  property p_dir_read;
    rd_i && addr_i == ADDR_LOW_PORT_DIRECTION |=> rdata_o[15:2] == 14'h3FFF;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction fixed bits wrong");
  property p_mode_read;
    rd_i && addr_i == ADDR_LOW_PORT_MODE_CONTROL |=> rdata_o[15:2] == 14'h0000;
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode upper bits not zero");
  property p_func_read;
    rd_i && addr_i == ADDR_LOW_PORT_FUNCTION_SELECT |=> rdata_o[15:2] == 14'h0000;
  endproperty
  a_func_read: assert property (p_func_read) else $error("function upper bits not zero");
  property p_trig_read;
    rd_i && (addr_i == ADDR_LOW_PORT_FALLING_SELECT || addr_i == ADDR_LOW_PORT_RISING_SELECT)
      |=> rdata_o[15:2] == 14'h0000;
  endproperty
  a_trig_read: assert property (p_trig_read) else $error("trigger upper bits not zero");
  property p_flag_hold;
    low_port_request_flag_o[0] && !low_port_request_clear_i[0] |=> low_port_request_flag_o[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");
  property p_c3_same;
    timer_c3_capture0_interrupt_input_o == timer_c3_count_input_o;
  endproperty
  a_c3_same: assert property (p_c3_same) else $error("capture and count inputs differ");
  property p_c3_excl;
    !(dma3_request_input_o && timer_c3_count_input_o);
  endproperty
  a_c3_excl: assert property (p_c3_excl) else $error("pin5 routed to both units");
  property p_c2_excl;
    !(dma2_request_input_o && timer_c2_count_input_o);
  endproperty
  a_c2_excl: assert property (p_c2_excl) else $error("pin2 routed to both units");
  property p_req_pad;
    $rose(dma3_request_input_o) |-> $past(timer_dma_pin_i[5], 4);
  endproperty
  a_req_pad: assert property (p_req_pad) else $error("request rose without pad high");
  c_flag: cover property ($rose(low_port_request_flag_o[0]));
  c_req: cover property ($rose(dma3_request_input_o));
  c_dir: cover property (rd_i && addr_i == ADDR_LOW_PORT_DIRECTION);
endmodule : port_pin_function_chk

// ===== port_pin_far.sv
/*
  Far-side model: external devices on the three pad groups.
  A pad shows the block's level where its buffer is on, else the
  level that the bench tells the device to apply.
*/
module port_pin_far (
  input wire logic [7:0] td_out_i,
  input wire logic [7:0] td_oe_i,
  input wire logic [7:0] td_dev_i,
  output logic [7:0] td_pad_o,
  input wire logic [1:0] lo_out_i,
  input wire logic [1:0] lo_oe_i,
  input wire logic [1:0] lo_dev_i,
  output logic [1:0] lo_pad_o,
  input wire logic [9:0] hi_out_i,
  input wire logic [9:0] hi_oe_i,
  input wire logic [9:0] hi_dev_i,
  output logic [9:0] hi_pad_o
);
  // Device drives only where the block has released the pad
  assign td_pad_o = (td_oe_i & td_out_i) | (~td_oe_i & td_dev_i);
  assign lo_pad_o = (lo_oe_i & lo_out_i) | (~lo_oe_i & lo_dev_i);
  assign hi_pad_o = (hi_oe_i & hi_out_i) | (~hi_oe_i & hi_dev_i);
endmodule : port_pin_far

// ===== port_pin_function_tb_top.sv
/*
  Self-checking bench for port_pin_function: reset values, masks,
  six-pin routing, address ports and low port triggers.
  Assumes port_pin_pkg, the far-side model and the checker compile first.
*/
module port_pin_function_tb_top import port_pin_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic [31:0] addr_i = 32'h0;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic pend = 1'h0;
  logic [15:0] wmask_i = 16'h0, wdata_i = 16'h0, rdata_o;
  logic [7:0] timer_dma_pin_i, timer_dma_pin_o, timer_dma_pin_oe_o, capt, td_dev = 8'h0;
  logic [1:0] low_port_pin_i, low_port_pin_o, low_port_pin_oe_o, lo_dev = 2'h3, address_low_i = 2'h1;
  logic [1:0] low_port_request_clear_i = 2'h0, low_port_request_flag_o;
  logic [9:0] high_port_pin_i, high_port_pin_o, high_port_pin_oe_o, hi_dev = 10'h0, address_high_i = 10'h2A5;
  logic [5:0] unit = 6'h0;
  logic [15:0] lfsr = 16'hA93F;
  logic [15:0] exp_q[$];
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  port_pin_function #(.SAMPLE_DIV(4)) DUT (.clk_i, .rstn_i, .addr_i, .wr_i, .rd_i, .wmask_i, .wdata_i,
    .rdata_o, .timer_dma_pin_i, .timer_dma_pin_o, .timer_dma_pin_oe_o, .low_port_pin_i, .low_port_pin_o,
    .low_port_pin_oe_o, .high_port_pin_i, .high_port_pin_o, .high_port_pin_oe_o,
    .timer_c3_compare_output_i(unit[0]), .dma3_transfer_end_output_i(unit[1]),
    .dma3_acknowledge_output_i(unit[2]), .timer_c2_compare_output_i(unit[3]),
    .dma2_transfer_end_output_i(unit[4]), .dma2_acknowledge_output_i(unit[5]), .address_low_i,
    .address_high_i, .timer_c3_capture1_interrupt_input_o(capt[7]),
    .timer_c3_capture0_interrupt_input_o(capt[6]), .timer_c3_count_input_o(capt[5]),
    .dma3_request_input_o(capt[4]), .timer_c2_capture1_interrupt_input_o(capt[3]),
    .timer_c2_capture0_interrupt_input_o(capt[2]), .timer_c2_count_input_o(capt[1]),
    .dma2_request_input_o(capt[0]), .low_port_request_clear_i, .low_port_request_flag_o);
  port_pin_far far (.td_out_i(timer_dma_pin_o), .td_oe_i(timer_dma_pin_oe_o), .td_dev_i(td_dev),
    .td_pad_o(timer_dma_pin_i), .lo_out_i(low_port_pin_o), .lo_oe_i(low_port_pin_oe_o),
    .lo_dev_i(lo_dev), .lo_pad_o(low_port_pin_i), .hi_out_i(high_port_pin_o),
    .hi_oe_i(high_port_pin_oe_o), .hi_dev_i(hi_dev), .hi_pad_o(high_port_pin_i));
  always #2 clk_i = ~clk_i;
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle
  task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [15:0] m);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wmask_i <= m;
    wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'h0;
  endtask : rd
  task automatic clr0();
    @(posedge clk_i);
    low_port_request_clear_i <= 2'h1;
    @(posedge clk_i);
    low_port_request_clear_i <= 2'h0;
  endtask : clr0
  // Read data lands on the edge that takes the read, so look half a cycle later
  always @(posedge clk_i) pend <= rd_i;
  always @(negedge clk_i) begin
    if (pend && exp_q.size() > 0) begin
      cmp(rdata_o, exp_q.pop_front());
    end
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    logic [31:0] ra [8];
    logic [15:0] re [8];
    logic [7:0] f;
    logic [7:0] x;
    logic [7:0] e;
    ra = '{ADDR_LOW_PORT_DIRECTION, ADDR_LOW_PORT_MODE_CONTROL, ADDR_LOW_PORT_FUNCTION_SELECT,
      ADDR_LOW_PORT_FALLING_SELECT, ADDR_LOW_PORT_RISING_SELECT, ADDR_HIGH_PORT_MODE_CONTROL,
      ADDR_TIMER_DMA_PIN_FUNCTION_SELECT, 32'hFFFFF004};
    re = '{16'hFFFF, 16'h0002, 16'h0003, 16'h0000, 16'h0003, 16'h03FF, 16'h0000, 16'h0000};
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'h1;
    settle(2);
    cmp({6'h0, high_port_pin_oe_o}, 16'h03FF);
    cmp({6'h0, high_port_pin_o}, 16'h02A5);
    cmp({14'h0, low_port_pin_oe_o}, 16'h0002);
    cmp({15'h0, low_port_pin_o[1]}, 16'h0000);
    for (int i = 0; i < 8; i++) rd(ra[i], re[i]);
    $display("reset values done");
    wr(ADDR_LOW_PORT_DIRECTION, 16'h0000, 16'hFFFF);
    rd(ADDR_LOW_PORT_DIRECTION, 16'hFFFC);
    settle(3);
    cmp({14'h0, low_port_pin_oe_o}, 16'h0003);
    wr(ADDR_LOW_PORT_DIRECTION, 16'h0001, 16'h0001);
    rd(ADDR_LOW_PORT_DIRECTION, 16'hFFFD);
    wr(ADDR_LOW_PORT_MODE_CONTROL, 16'hFFFF, 16'hFFFF);
    rd(ADDR_LOW_PORT_MODE_CONTROL, 16'h0003);
    settle(3);
    cmp({12'h0, low_port_pin_oe_o, low_port_pin_o}, 16'h000D);
    wr(ADDR_LOW_PORT_FUNCTION_SELECT, 16'h0000, 16'h0001);
    settle(3);
    cmp({14'h0, low_port_pin_oe_o}, 16'h0002);
    $display("low port registers done");
    // Trigger codes in turn: fall, rise, low level, both edges on pin 0
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_LOW_PORT_FALLING_SELECT, {15'h0, m[1]}, 16'h0001);
      wr(ADDR_LOW_PORT_RISING_SELECT, {15'h0, m[0]}, 16'h0001);
      settle(12);
      clr0();
      @(posedge clk_i);
      lo_dev <= 2'h2;
      settle(12);
      cmp({15'h0, low_port_request_flag_o[0]}, {15'h0, m != 1});
      clr0();
      settle(6);
      cmp({15'h0, low_port_request_flag_o[0]}, {15'h0, m == 2});
      @(posedge clk_i);
      lo_dev <= 2'h3;
      settle(12);
      cmp({15'h0, low_port_request_flag_o[0]}, {15'h0, m != 0});
      clr0();
      settle(2);
      cmp({15'h0, low_port_request_flag_o[0]}, 16'h0000);
    end
    $display("trigger modes done");
    wr(ADDR_TIMER_DMA_PIN_MODE_CONTROL, 16'h00FC, 16'h00FF);
    for (int i = 0; i < 16; i++) begin
      lfsr = nxt(lfsr);
      f = lfsr[7:0] & 8'hFC;
      x = lfsr[15:8];
      lfsr = nxt(lfsr);
      e = lfsr[7:0];
      @(posedge clk_i);
      unit <= x[5:0];
      td_dev <= e;
      wr(ADDR_TIMER_DMA_PIN_FUNCTION_SELECT, {8'h00, f}, 16'h00FF);
      settle(8);
      cmp({8'h0, timer_dma_pin_oe_o}, {8'h0, 1'h1, f[6], 2'h1, f[3], 3'h0});
      cmp({8'h0, timer_dma_pin_o & {1'h1, f[6], 2'h1, f[3], 3'h0}},
        {8'h0, f[7] ? x[1] : x[0], f[6] & x[2], 1'h0, f[4] ? x[4] : x[3], f[3] & x[5], 3'h0});
      cmp({8'h0, capt}, {8'h0, ~f[6] & e[6], {2{~f[5] & e[5]}}, f[5] & e[5], ~f[3] & e[3],
        {2{~f[2] & e[2]}}, f[2] & e[2]});
    end
    wr(ADDR_TIMER_DMA_PIN_MODE_CONTROL, 16'h0000, 16'h00FF);
    settle(8);
    cmp({timer_dma_pin_oe_o, capt}, 16'h0000);
    $display("six-pin routing done");
    wr(ADDR_HIGH_PORT_MODE_CONTROL, 16'h0000, 16'hFF00);
    rd(ADDR_HIGH_PORT_MODE_CONTROL, 16'h00FF);
    settle(3);
    cmp({6'h0, high_port_pin_oe_o}, 16'h00FF);
    cmp({8'h0, high_port_pin_o[7:0]}, {8'h0, address_high_i[7:0]});
    wr(ADDR_HIGH_PORT_DIRECTION, 16'h0000, 16'hFFFF);
    settle(3);
    cmp({6'h0, high_port_pin_oe_o}, 16'h03FF);
    wr(ADDR_HIGH_PORT_PIN_DATA, 16'h0100, 16'hFFFF);
    rd(ADDR_HIGH_PORT_PIN_DATA, 16'h0100);
    settle(3);
    cmp({6'h0, high_port_pin_o}, 16'h01A5);
    wr(ADDR_LOW_PORT_PIN_DATA, 16'h0000, 16'hFFFF);
    rd(ADDR_LOW_PORT_PIN_DATA, 16'h0001);
    $display("high port done");
    settle(2);
    end_sim();
  end
endmodule : port_pin_function_tb_top

bind port_pin_function port_pin_function_chk u_chk (.clk_i, .rstn_i, .addr_i, .rd_i, .rdata_o,
  .timer_dma_pin_i, .low_port_request_clear_i, .low_port_request_flag_o,
  .timer_c3_capture0_interrupt_input_o, .timer_c3_count_input_o, .dma3_request_input_o,
  .timer_c2_count_input_o, .dma2_request_input_o);
